//--- include/ir_remote_pkg.sv
// Constants, register map and timing for the infrared key encoder.
// Assumes a 100 MHz bus clock and an AHB-Lite register slave.
// What this block does
// - Scan 8 columns by 6 rows, 48 keys
// - Five strobes driven one at a time
// - Custom-code line picks the frame custom code
// - Reset while pin low, resume when high
// - Standby after reset and after empty passes
// - Standby stops oscillator, strobes low
// - Standby holds custom-code line high
// - Any key going low wakes the device
// - Carrier near 37.91 kHz from 455 kHz
// - Repeat frames while key stays down
// - Two keys together give no code, except a direct key with a strobed key in its column
// - Keys 1-32 code is key-1 plus 32 times page
// - Keys 33-48 use fixed lookup per page
// - Carrier is oscillator divided by twelve
// - Carrier high one third of period
package ir_remote_pkg;
   // Oscillator model and carrier
   localparam int unsigned CLK_FREQ_HZ  = 100_000_000;
   localparam int unsigned OSC_FREQ_HZ  = 455_000;
   localparam int unsigned OSC_DIV      = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam int unsigned CAR_DIV      = 12;
   localparam int unsigned CAR_HIGH     = CAR_DIV / 3;
   localparam int unsigned SETTLE_TICKS = 2;
   // Frame timing in carrier periods
   localparam int unsigned LEAD_MARK_CAR  = 342;
   localparam int unsigned LEAD_SPACE_CAR = 171;
   localparam int unsigned BIT_MARK_CAR   = 21;
   localparam int unsigned ZERO_SPACE_CAR = 21;
   localparam int unsigned ONE_SPACE_CAR  = 64;
   localparam int unsigned FRAME_INT_CAR  = 4096;
   // Register map
   localparam logic [7:0]  CTRL_OFS         = 8'h00;
   localparam logic [7:0]  STATUS_OFS       = 8'h04;
   localparam logic [7:0]  CUSTOM_OFS       = 8'h08;
   localparam logic [2:0]  HSIZE_WORD       = 3'h2;
   localparam logic        CTRL_TX_EN_RESET = 1'b1;
   localparam logic [7:0]  CUSTOM_LO_RESET  = 8'h00;
   localparam logic [7:0]  CUSTOM_HI_RESET  = 8'hFF;
   localparam int unsigned ST_STANDBY_BIT   = 0;
   localparam int unsigned ST_BUSY_BIT      = 1;
   localparam int unsigned ST_MULTI_BIT     = 2;
   localparam int unsigned ST_CODE_LSB      = 8;
   localparam int unsigned ST_PAGE_LSB      = 16;
   localparam int unsigned ST_CUSTOM_BIT    = 19;
   localparam int unsigned CUSTOM_HI_LSB    = 8;
endpackage : ir_remote_pkg

//--- include/ir_tx_if.sv
// Link between the key scanner and the frame transmitter.
// Assumes both ends run on hclk.
`timescale 1ns/100ps
interface ir_tx_if;
   logic        osc_tick;
   logic        start;
   logic [15:0] frame_word;
   logic        busy;
   modport ctl (output osc_tick, output start, output frame_word, input busy);
   modport tx  (input osc_tick, input start, input frame_word, output busy);
endinterface : ir_tx_if

//--- rtl/key_code_map.sv
// Key number and code page to 8-bit key code.
// Assumes key numbers 1 to 48; others give a don't-care code.
`timescale 1ns/100ps
module key_code_map (
   // Key and code page
   input  wire logic [5:0] key_num,
   input  wire logic [2:0] page,
   // Resulting code
   output logic      [7:0] code
);
   // One byte per page, page 0 lowest; irregular entries are intentional
   localparam logic [63:0] EXT_TABLE [16] = '{
      64'h00E0C0A080504020, 64'h01E1C1A181514121, 64'h02E2C2A282524222,
      64'h03E3C3A383534323, 64'h14F4D4B494745434, 64'h15F5D5B595755535,
      64'h16F6D6B696765636, 64'h17F7D7B797775737, 64'h3818F8D8B8987858,
      64'h3919F9D9B99A7959, 64'h3A1AFADABA9B7A5A, 64'h3B1BFBDBBB9C7B5B,
      64'h7C5C3C1CFCDCBC9C, 64'h7D5D3D1DFDDDBD9D, 64'h7E5E3E1EFEDEBE9E,
      64'h7F5F3F1FFFDFBF9F};
   wire [5:0]  key_m1  = key_num - 6'h01;
   wire [5:0]  ext_idx = key_num - 6'h21;
   wire [63:0] ext_row = EXT_TABLE[ext_idx[3:0]];
   wire [7:0]  simple  = {page, key_m1[4:0]};
   wire [7:0]  ext     = ext_row[{page, 3'h0} +: 8];
   assign code = (key_num <= 6'h20) ? simple : ext;
endmodule : key_code_map

//--- rtl/ir_frame_tx.sv
// Frame serializer and carrier modulator.
// Assumes osc_tick pulses once per oscillator period and stops in standby.
`timescale 1ns/100ps
module ir_frame_tx #(
   parameter int unsigned LEAD_MARK  = ir_remote_pkg::LEAD_MARK_CAR,
   parameter int unsigned LEAD_SPACE = ir_remote_pkg::LEAD_SPACE_CAR,
   parameter int unsigned BIT_MARK   = ir_remote_pkg::BIT_MARK_CAR,
   parameter int unsigned ZERO_SPACE = ir_remote_pkg::ZERO_SPACE_CAR,
   parameter int unsigned ONE_SPACE  = ir_remote_pkg::ONE_SPACE_CAR,
   parameter int unsigned FRAME_INT  = ir_remote_pkg::FRAME_INT_CAR
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Request from the scanner
   ir_tx_if.tx       link,
   // Modulated output
   output logic      ir_out
);
   typedef enum logic [2:0] {TX_IDLE, TX_LEAD_MARK, TX_LEAD_SPACE, TX_BIT_MARK,
                             TX_BIT_SPACE, TX_STOP, TX_WAIT} tx_state_e;
   tx_state_e   state_reg;
   logic [3:0]  car_cnt_reg;
   logic [3:0]  bit_reg;
   logic [15:0] seg_reg;
   logic [15:0] frame_reg;
   logic [15:0] shift_reg;
   wire         car_wrap  = link.osc_tick && car_cnt_reg == 4'(ir_remote_pkg::CAR_DIV - 1);
   wire         seg_done  = car_wrap && seg_reg == 16'h0000;
   wire         marking   = state_reg inside {TX_LEAD_MARK, TX_BIT_MARK, TX_STOP};
   wire [15:0]  space_len = shift_reg[0] ? 16'(ONE_SPACE - 1) : 16'(ZERO_SPACE - 1);
   assign link.busy = state_reg != TX_IDLE;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg   <= TX_IDLE;
         car_cnt_reg <= 4'h0;
         bit_reg     <= 4'h0;
         seg_reg     <= 16'h0000;
         frame_reg   <= 16'h0000;
         shift_reg   <= 16'h0000;
         ir_out      <= 1'b0;
      end else begin
         // High for a third of each period
         ir_out <= marking && car_cnt_reg < 4'(ir_remote_pkg::CAR_HIGH);
         if (state_reg == TX_IDLE) begin
            car_cnt_reg <= 4'h0;
            frame_reg   <= 16'h0000;
            // Start on a tick so every carrier pulse is whole
            if (link.start && link.osc_tick) begin
               state_reg <= TX_LEAD_MARK;
               seg_reg   <= 16'(LEAD_MARK - 1);
               shift_reg <= link.frame_word;
               bit_reg   <= 4'h0;
            end
         end else begin
            if (link.osc_tick) begin
               car_cnt_reg <= car_wrap ? 4'h0 : car_cnt_reg + 4'h1;
            end
            if (car_wrap) begin
               frame_reg <= frame_reg + 16'h0001;
               seg_reg   <= seg_reg - 16'h0001;
            end
            if (seg_done) begin
               unique case (state_reg)
                  TX_LEAD_MARK: begin
                     state_reg <= TX_LEAD_SPACE;
                     seg_reg   <= 16'(LEAD_SPACE - 1);
                  end
                  TX_LEAD_SPACE: begin
                     state_reg <= TX_BIT_MARK;
                     seg_reg   <= 16'(BIT_MARK - 1);
                  end
                  TX_BIT_MARK: begin
                     state_reg <= TX_BIT_SPACE;
                     seg_reg   <= space_len;
                  end
                  TX_BIT_SPACE: begin
                     state_reg <= (bit_reg == 4'hF) ? TX_STOP : TX_BIT_MARK;
                     seg_reg   <= 16'(BIT_MARK - 1);
                     shift_reg <= shift_reg >> 1;
                     bit_reg   <= bit_reg + 4'h1;
                  end
                  TX_STOP: state_reg <= TX_WAIT;
                  TX_WAIT, TX_IDLE: ;
                  default: state_reg <= TX_IDLE;
               endcase
            end
            if (state_reg == TX_WAIT && frame_reg >= 16'(FRAME_INT - 1)) begin
               state_reg <= TX_IDLE;
            end
         end
      end
   end
endmodule : ir_frame_tx

//--- rtl/ir_remote_key_encoder.sv
// Key-matrix infrared remote encoder with an AHB-Lite status port.
// Assumes key inputs are synchronous to hclk and pulled up on the board.
`timescale 1ns/100ps
module ir_remote_key_encoder #(
   parameter int unsigned OSC_DIV    = ir_remote_pkg::OSC_DIV,
   parameter int unsigned LEAD_MARK  = ir_remote_pkg::LEAD_MARK_CAR,
   parameter int unsigned LEAD_SPACE = ir_remote_pkg::LEAD_SPACE_CAR,
   parameter int unsigned BIT_MARK   = ir_remote_pkg::BIT_MARK_CAR,
   parameter int unsigned ZERO_SPACE = ir_remote_pkg::ZERO_SPACE_CAR,
   parameter int unsigned ONE_SPACE  = ir_remote_pkg::ONE_SPACE_CAR,
   parameter int unsigned FRAME_INT  = ir_remote_pkg::FRAME_INT_CAR
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Key matrix
   input  wire logic [3:0]  key_input_low_group,
   input  wire logic [3:0]  key_input_high_group,
   output logic      [3:0]  scan_strobe_lines,
   output logic             scan_strobe_four_line,
   // Custom-code line, two-way
   input  wire logic        custom_code_select_line_in,
   output logic             custom_code_select_line_out,
   output logic             custom_code_select_line_oe,
   // Code page diodes
   input  wire logic [2:0]  code_page_select_diodes,
   // Infrared output
   output logic             ir_transmit_output
);
   localparam int OSC_W = $clog2(OSC_DIV);
   typedef enum logic [1:0] {ST_STANDBY, ST_SCAN, ST_SEND, ST_WAIT} scan_state_e;

   function automatic logic [3:0] count_ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction : count_ones

   function automatic logic [2:0] lowest_col(input logic [7:0] v);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            c = 3'(i);
         end
      end
      return c;
   endfunction : lowest_col

   scan_state_e state_reg;
   scan_state_e state_next;
   logic [2:0]       row_reg;
   logic [1:0]       settle_reg;
   logic [7:0]       direct_mask_reg;
   logic [1:0]       key_cnt_reg;
   logic [5:0]       key_num_reg;
   logic [7:0]       last_code_reg;
   logic             multi_reg;
   logic             custom_sel_reg;
   logic             start_reg;
   logic [4:0]       strobe_reg;
   logic             cc_oe_reg;
   logic [OSC_W-1:0] osc_cnt_reg;
   logic             osc_tick_reg;
   logic [2:0]       page_reg;
   logic             page_taken_reg;
   logic             tx_en_reg;
   logic [7:0]       custom_lo_reg;
   logic [7:0]       custom_hi_reg;
   logic             wr_pend_reg;
   logic [7:0]       wr_addr_reg;
   logic [31:0]      hrdata_reg;
   logic [7:0]       key_code;
   ir_tx_if tx_link ();

   // Low level on either group marks a key
   wire [7:0] key_low    = ~{key_input_high_group, key_input_low_group};
   wire       any_key    = |key_low;
   wire       st_standby = state_reg == ST_STANDBY;
   wire       st_scan    = state_reg == ST_SCAN;
   wire       direct_row = row_reg == 3'h0;
   wire       row_sample = st_scan && osc_tick_reg &&
                           settle_reg == 2'(ir_remote_pkg::SETTLE_TICKS - 1);
   wire       pass_end   = row_sample && row_reg == 3'h5;
   // Keys without a strobe show in every row, so they are masked out
   wire [7:0] row_hits   = direct_row ? key_low : key_low & ~direct_mask_reg;
   wire [3:0] cnt_sum    = {2'h0, key_cnt_reg} + count_ones(row_hits);
   wire [1:0] cnt_next   = (cnt_sum > 4'h2) ? 2'h2 : cnt_sum[1:0];
   // Strobe rows give keys 1-40, direct row 41-48
   wire [5:0] row_base   = direct_row ? 6'h28 : {row_reg - 3'h1, 3'h0};
   wire [5:0] hit_key    = row_base + {3'h0, lowest_col(row_hits)} + 6'h01;
   wire       scan_restart = state_next == ST_SCAN && (!st_scan || pass_end);
   // One strobe low per row, none for the direct row
   wire [4:0] strobe_next = st_standby ? 5'h00 :
                            (st_scan && !direct_row) ? ~(5'h01 << (row_reg - 3'h1)) : 5'h1F;
   // Custom code chosen by the sampled line
   wire [7:0] custom_code = custom_sel_reg ? custom_hi_reg : custom_lo_reg;

   key_code_map u_map (
      .key_num (key_num_reg),
      .page    (page_reg),
      .code    (key_code)
   );

   assign tx_link.osc_tick   = osc_tick_reg;
   assign tx_link.start      = start_reg;
   assign tx_link.frame_word = {key_code, custom_code};

   ir_frame_tx #(
      .LEAD_MARK  (LEAD_MARK),
      .LEAD_SPACE (LEAD_SPACE),
      .BIT_MARK   (BIT_MARK),
      .ZERO_SPACE (ZERO_SPACE),
      .ONE_SPACE  (ONE_SPACE),
      .FRAME_INT  (FRAME_INT)
   ) u_tx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .link    (tx_link.tx),
      .ir_out  (ir_transmit_output)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_STANDBY: begin
            if (any_key) begin
               state_next = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (pass_end) begin
               if (cnt_next == 2'h0) begin
                  state_next = ST_STANDBY;
               end else if (cnt_next == 2'h1 && tx_en_reg) begin
                  // Only a lone key is sent
                  state_next = ST_SEND;
               end
            end
         end
         ST_SEND: begin
            if (tx_link.busy) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!tx_link.busy) begin
               state_next = ST_SCAN;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= ST_STANDBY;
         start_reg    <= 1'b0;
         strobe_reg   <= 5'h00;
         cc_oe_reg    <= 1'b1;
      end else begin
         state_reg    <= state_next;
         start_reg    <= state_next == ST_SEND;
         strobe_reg   <= strobe_next;
         // Custom line driven high in standby
         cc_oe_reg    <= state_next == ST_STANDBY;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt_reg  <= '0;
         osc_tick_reg <= 1'b0;
      end else if (st_standby) begin
         osc_cnt_reg  <= '0;
         osc_tick_reg <= 1'b0;
      end else begin
         // Oscillator rate from the bus clock
         osc_tick_reg <= osc_cnt_reg == OSC_W'(OSC_DIV - 1);
         osc_cnt_reg  <= (osc_cnt_reg == OSC_W'(OSC_DIV - 1)) ? '0 : osc_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_reg         <= 3'h0;
         settle_reg      <= 2'h0;
         direct_mask_reg <= 8'h00;
         key_cnt_reg     <= 2'h0;
         key_num_reg     <= 6'h01;
         multi_reg       <= 1'b0;
         custom_sel_reg  <= 1'b0;
      end else if (scan_restart) begin
         row_reg         <= 3'h0;
         settle_reg      <= 2'h0;
         direct_mask_reg <= 8'h00;
         key_cnt_reg     <= 2'h0;
         // A crowded pass rescans, so its verdict is kept here too
         if (pass_end) begin
            multi_reg      <= cnt_next == 2'h2;
            custom_sel_reg <= custom_code_select_line_in;
         end
      end else if (row_sample) begin
         row_reg         <= row_reg + 3'h1;
         settle_reg      <= 2'h0;
         key_cnt_reg     <= cnt_next;
         if (direct_row) begin
            direct_mask_reg <= key_low;
         end
         if (key_cnt_reg == 2'h0 && row_hits != 8'h00) begin
            key_num_reg  <= hit_key;
         end
         if (pass_end) begin
            multi_reg      <= cnt_next == 2'h2;
            custom_sel_reg <= custom_code_select_line_in;
         end
      end else if (st_scan && osc_tick_reg) begin
         settle_reg      <= settle_reg + 2'h1;
      end
   end

   // Diode pattern taken once after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_reg       <= 3'h0;
         page_taken_reg <= 1'b0;
         last_code_reg  <= 8'h00;
      end else begin
         if (!page_taken_reg) begin
            page_reg       <= code_page_select_diodes;
            page_taken_reg <= 1'b1;
         end
         if (start_reg) begin
            last_code_reg  <= key_code;
         end
      end
   end

   // Bus slave: zero wait, read data captured in the address phase
   wire        ahb_take  = hsel && htrans[1] && hready;
   wire        ahb_wr    = ahb_take && hwrite && hsize == ir_remote_pkg::HSIZE_WORD;
   wire [31:0] status_word = (32'(st_standby) << ir_remote_pkg::ST_STANDBY_BIT) |
                             (32'(tx_link.busy) << ir_remote_pkg::ST_BUSY_BIT) |
                             (32'(multi_reg) << ir_remote_pkg::ST_MULTI_BIT) |
                             (32'(last_code_reg) << ir_remote_pkg::ST_CODE_LSB) |
                             (32'(page_reg) << ir_remote_pkg::ST_PAGE_LSB) |
                             (32'(custom_sel_reg) << ir_remote_pkg::ST_CUSTOM_BIT);
   wire [31:0] read_word =
      (haddr[7:0] == ir_remote_pkg::CTRL_OFS)   ? {31'h0, tx_en_reg} :
      (haddr[7:0] == ir_remote_pkg::STATUS_OFS) ? status_word :
      (haddr[7:0] == ir_remote_pkg::CUSTOM_OFS) ? {16'h0, custom_hi_reg, custom_lo_reg} :
      32'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg   <= 1'b0;
         wr_addr_reg   <= 8'h00;
         hrdata_reg    <= 32'h0;
         tx_en_reg     <= ir_remote_pkg::CTRL_TX_EN_RESET;
         custom_lo_reg <= ir_remote_pkg::CUSTOM_LO_RESET;
         custom_hi_reg <= ir_remote_pkg::CUSTOM_HI_RESET;
      end else begin
         wr_pend_reg   <= ahb_wr;
         wr_addr_reg   <= haddr[7:0];
         hrdata_reg    <= (ahb_take && !hwrite) ? read_word : 32'h0;
         if (wr_pend_reg && wr_addr_reg == ir_remote_pkg::CTRL_OFS) begin
            tx_en_reg     <= hwdata[0];
         end
         if (wr_pend_reg && wr_addr_reg == ir_remote_pkg::CUSTOM_OFS) begin
            custom_lo_reg <= hwdata[7:0];
            custom_hi_reg <= hwdata[ir_remote_pkg::CUSTOM_HI_LSB +: 8];
         end
      end
   end

   assign hrdata                      = hrdata_reg;
   assign hreadyout                   = 1'b1;
   assign hresp                       = 1'b0;
   assign scan_strobe_lines           = strobe_reg[3:0];
   assign scan_strobe_four_line       = strobe_reg[4];
   assign custom_code_select_line_out = 1'b1;
   assign custom_code_select_line_oe  = cc_oe_reg;

   // Helper: oscillator ticks seen while the carrier is high
   logic [3:0] hi_ticks_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_ticks_reg <= 4'h0;
      end else if (!ir_transmit_output) begin
         hi_ticks_reg <= 4'h0;
      end else if (osc_tick_reg) begin
         hi_ticks_reg <= hi_ticks_reg + 4'h1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_standby_strobe_low: assert property (st_standby && $past(st_standby) |->
      scan_strobe_lines == 4'h0 && !scan_strobe_four_line) else $error("Strobe high in standby");
   a_standby_osc_stop: assert property (st_standby && $past(st_standby) |->
      !osc_tick_reg) else $error("Oscillator runs in standby");
   a_custom_held_high: assert property (st_standby && $past(st_standby) |->
      custom_code_select_line_oe && custom_code_select_line_out) else $error("Line not high");
   a_wake_on_key: assert property (st_standby && any_key |=> st_scan ##1
      scan_strobe_lines == 4'hF) else $error("No wake on key");
   a_empty_pass_sleep: assert property (pass_end && cnt_next == 2'h0 |=>
      st_standby) else $error("No standby after empty pass");
   a_one_strobe: assert property (!st_standby && !$past(st_standby) |->
      $onehot0(~{scan_strobe_four_line, scan_strobe_lines})) else $error("Two strobes low");
   a_single_key_send: assert property ($rose(start_reg) |->
      key_cnt_reg == 2'h1 && !multi_reg) else $error("Frame for several keys");
   a_simple_code: assert property (start_reg && key_num_reg <= 6'h20 |->
      tx_link.frame_word[15:8] == {page_reg, 5'(key_num_reg - 6'h01)}) else $error("Bad code");
   a_carrier_duty: assert property ($fell(ir_transmit_output) |->
      hi_ticks_reg == 4'(ir_remote_pkg::CAR_HIGH)) else $error("Carrier duty wrong");
   a_repeat_rescan: assert property (state_reg == ST_WAIT && !tx_link.busy |=>
      st_scan && row_reg == 3'h0) else $error("No rescan after frame");
   a_multi_no_send: assert property (pass_end && cnt_next == 2'h2 |=>
      !start_reg && multi_reg) else $error("Frame started for several keys");
   a_ext_code: assert property (start_reg && key_num_reg == 6'h2D |->
      page_reg != 3'h0 || tx_link.frame_word[15:8] == 8'h9C) else $error("Bad extended code");
   a_standby_quiet: assert property (st_standby |->
      !tx_link.busy && !ir_transmit_output) else $error("Transmitter active in standby");
   a_send_after_pass: assert property ($rose(start_reg) |->
      $past(pass_end)) else $error("Frame without a full pass");
endmodule : ir_remote_key_encoder

//--- verif/ir_rx_model.sv
// Receiver model: measures carrier pulses on the LED line.
// Assumes the LED line is registered on hclk, one-carrier marks and
// spaces of one or three carriers, so rise spacing alone gives each bit.
`timescale 1ns/100ps
module ir_rx_model #(
   parameter int CAR = 48
) (
   // Clock and LED line
   input  wire logic   hclk,
   input  wire logic   ir,
   // Measurements
   output int          pulses,
   output int          hi_len,
   output int          per_min,
   output logic [15:0] word
);
   int   cnt  = 0;
   logic ir_q = 1'b0;
   initial begin
      pulses  = 0;
      hi_len  = 0;
      per_min = 99999;
      word    = 16'h0000;
   end
   always @(posedge hclk) begin
      cnt  <= cnt + 1;
      ir_q <= ir;
      if (ir && !ir_q) begin
         pulses <= pulses + 1;
         cnt    <= 1;
         if (cnt < per_min) per_min <= cnt;
         // Two carriers rise to rise is a 0, four a 1, LSB first
         if (cnt == 2 * CAR) word <= {1'b0, word[15:1]};
         if (cnt == 4 * CAR) word <= {1'b1, word[15:1]};
      end
      if (!ir && ir_q) hi_len <= cnt;
   end
endmodule : ir_rx_model

//--- verif/tb_top.sv
// Bench for the key encoder: bus master, key matrix, receiver.
// Assumes shortened frame counts and a 4-cycle oscillator tick.
`timescale 1ns/100ps
module tb_top;
   localparam int unsigned DIV = 4;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, c_out, c_oe, ir;
   logic [7:0]  cols;
   logic [4:0]  strb;
   logic [47:0] pressed = 48'h0;
   logic        cust_drv = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [2:0]  diodes = 3'b001;
   logic [15:0] rx_word;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          pulses, hi_len, per_min;
   always #5 hclk = ~hclk;
   // Direct row always live; other rows only while their strobe is low
   always_comb begin
      cols = 8'hFF;
      for (int k = 0; k < 48; k++)
         if (pressed[k] && (k >= 40 || !strb[k / 8])) cols[k % 8] = 1'b0;
   end
   ir_remote_key_encoder #(.OSC_DIV(DIV), .LEAD_MARK(4), .LEAD_SPACE(2), .BIT_MARK(1),
      .ZERO_SPACE(1), .ONE_SPACE(3), .FRAME_INT(128)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .key_input_low_group(cols[3:0]), .key_input_high_group(cols[7:4]),
      .scan_strobe_lines(strb[3:0]), .scan_strobe_four_line(strb[4]),
      .custom_code_select_line_in(c_oe ? c_out : cust_drv),
      .custom_code_select_line_out(c_out), .custom_code_select_line_oe(c_oe),
      // First diode fitted, others open; changed only in reset
      .code_page_select_diodes(diodes), .ir_transmit_output(ir));
   ir_rx_model #(.CAR(ir_remote_pkg::CAR_DIV * DIV)) i_rx (.hclk(hclk), .ir(ir),
      .pulses(pulses), .hi_len(hi_len), .per_min(per_min), .word(rx_word));
   task automatic conclude();
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic hang();
      error_cnt++;
      conclude();
   endtask : hang
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdy();
      for (int n = 0; n < 20; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) return;
      end
      hang();
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask : bus
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      for (int n = 0; n < 4000; n++) begin
         bus(1'b0, ir_remote_pkg::STATUS_OFS, 32'h0);
         if ((q & m) === v) return;
      end
      hang();
   endtask : poll
   task automatic wait_pul(input int n);
      for (int i = 0; i < 20000 && pulses < n; i++) @(posedge hclk);
      if (pulses < n) hang();
   endtask : wait_pul
   task automatic t_reset();
      bus(1'b0, ir_remote_pkg::CTRL_OFS, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, ir_remote_pkg::CUSTOM_OFS, 32'h0);
      chk(q, 32'h0000FF00);
      bus(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, ir_remote_pkg::STATUS_OFS, 32'h0);
      chk(q & 32'h00070001, 32'h00010001);
      chk({27'h0, strb}, 32'h0);
      chk({31'h0, c_oe & c_out}, 32'h1);
   endtask : t_reset
   task automatic t_key(input int k, input logic [7:0] code);
      int p0;
      p0 = pulses;
      pressed[k - 1] <= 1'b1;
      wait_pul(p0 + 42);
      chk(rx_word, {code, 8'h00});
      poll(32'h0000FF00, {16'h0, code, 8'h0});
      chk(hi_len, ir_remote_pkg::CAR_HIGH * DIV);
      chk(per_min, ir_remote_pkg::CAR_DIV * DIV);
      pressed[k - 1] <= 1'b0;
      poll(32'h1, 32'h1);
      chk((pulses - p0) % 21, 32'h0);
      chk({27'h0, strb}, 32'h0);
   endtask : t_key
   task automatic t_two();
      int p0;
      bus(1'b1, ir_remote_pkg::CUSTOM_OFS, 32'h0000A55A);
      // Byte-sized write must leave the register alone
      hsize <= 3'h0;
      bus(1'b1, ir_remote_pkg::CUSTOM_OFS, 32'h00001234);
      hsize <= 3'h2;
      bus(1'b0, ir_remote_pkg::CUSTOM_OFS, 32'h0);
      chk(q, 32'h0000A55A);
      cust_drv <= 1'b1;
      p0 = pulses;
      pressed <= 48'h3;
      poll(32'h4, 32'h4);
      chk(q[19], 32'h1);
      chk(pulses, p0);
      pressed <= 48'h0;
      poll(32'h1, 32'h1);
      chk(pulses, p0);
      pressed <= 48'h1;
      wait_pul(p0 + 21);
      chk(rx_word, 32'h20A5);
      pressed <= 48'h0;
      poll(32'h1, 32'h1);
      chk(pulses - p0, 32'h15);
   endtask : t_two
   task automatic t_page();
      hresetn  <= 1'b0;
      diodes   <= 3'b000;
      cust_drv <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, ir_remote_pkg::STATUS_OFS, 32'h0);
      chk(q & 32'h00070001, 32'h00000001);
      t_key(45, 8'h9C);
   endtask : t_page
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_key(1, 8'h20);
      t_key(32, 8'h3F);
      t_key(33, 8'h40);
      t_key(45, 8'hBC);
      t_two();
      t_page();
      conclude();
   end
endmodule : tb_top
